// *** rtl/csq_clutch_seq.sv ***
// Clutch sequencer, input F handling, alarm reset pulse and input supervision
`timescale 1ns/1ps
// How it works
// [R1] Torque-limit enable with clutch closed caps load; cap drops when input clears.
// [R2] Configuration flag chooses input F role: torque limit (default) or de-clutch.
// [R3] In de-clutch role, input F true opens permissive at once, skipping unload.
// [R4] After emergency de-clutch, no clutching until input F goes false.
// [R5] Request with other engine free: ramp to idle, dwell, close permissive.
// [R6] Request with other engine clutched: ramp to its speed, dwell, close permissive.
// [R7] Permissive reopens if engaged input stays false past the engage timeout.
// [R8] Engaged while joining: soft load until loads match, then load share.
// [R9] Dwell time, speed window and load rate are separate tunables.
// [R10] Request drops, other engine free: permissive opens immediately.
// [R11] Request drops, other clutched: unload at rate, open at trip level.
// [R12] Engaged input means clutch closed, feeding clutching, sharing, dynamics.
// [R13] Each analog input fails below 2.0 mA/0.5 V or above 22 mA/5.5 V.
// [R14] Analog failure stays latched until back in range and alarm reset.
// [R15] Failed rack input: scaled actuator output replaces rack reading.
// [R16] Failed remote reference: hold last valid value when configured.
// [R17] Failed manifold pressure: pressure fuel limit disabled.
// [R18] Alarm reset is a fixed short pulse on rising request, re-armed on release.
// [R19] Alarm reset request is OR of contact, serial command and software switch.
// [R20] Engage timer starts at permissive close, stops on engaged or permissive open.
// [R21] Sync dwell counts only inside speed window, restarts on leaving it.
module csq_clutch_seq #(
    parameter int W = 16,
    parameter int unsigned TICK_CYCLES = csq_pkg::TICK_CYCLES,
    parameter int unsigned RESET_PULSE_TICKS = csq_pkg::RESET_PULSE_TICKS
) (
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic reset_in,
    // Discrete inputs
    input wire logic input_f_in,
    input wire logic clutch_request_in,
    input wire logic clutch_engaged_in,
    input wire logic other_clutched_in,
    // Alarm reset sources
    input wire logic reset_contact_in,
    input wire logic reset_serial_in,
    input wire logic reset_soft_in,
    // Configuration and tunables
    input wire logic input_f_function_select_in,
    input wire logic hold_remote_on_fail_in,
    input wire logic [2:0] volt_mode_in,
    input wire logic [15:0] sync_dwell_ms_in,
    input wire logic [W-1:0] speed_window_in,
    input wire logic [6:0] engage_timeout_s_in,
    input wire logic [W-1:0] load_rate_in,
    input wire logic [W-1:0] unload_rate_in,
    input wire logic [W-1:0] unload_trip_in,
    // Process values
    input wire logic [W-1:0] idle_speed_in,
    input wire logic [W-1:0] other_speed_in,
    input wire logic [W-1:0] engine_speed_in,
    input wire logic [W-1:0] own_load_in,
    input wire logic [W-1:0] other_load_in,
    input wire logic [W-1:0] actuator_scaled_in,
    input wire logic [W-1:0] ain_rack_in,
    input wire logic [W-1:0] ain_remote_in,
    input wire logic [W-1:0] ain_map_in,
    // Clutch and load outputs
    output logic permissive_out,
    output logic torque_limit_active_out,
    output logic declutch_cmd_out,
    output logic clutch_closed_out,
    output logic sync_target_valid_out,
    output logic [W-1:0] speed_target_out,
    output logic [W-1:0] load_ref_out,
    output logic load_sharing_out,
    // Supervision outputs
    output logic alarm_reset_out,
    output logic [2:0] ain_failed_out,
    output logic [W-1:0] rack_value_out,
    output logic [W-1:0] remote_ref_out,
    output logic map_limit_enable_out
);
    initial begin
        if (W < 16) $error("csq_clutch_seq: W must be at least 16");
        if (TICK_CYCLES < 2 || RESET_PULSE_TICKS < 1 || RESET_PULSE_TICKS > 65535) begin
            $error("csq_clutch_seq: bad timing parameter");
        end
    end

    // ------------------------------------------------------------
    // Millisecond tick shared by every timer
    // ------------------------------------------------------------
    logic [31:0] tick_cnt_q;
    logic tick;
    assign tick = (tick_cnt_q == 32'(TICK_CYCLES - 1));
    always_ff @(posedge ref_clk_in) begin
        if (reset_in || tick) begin
            tick_cnt_q <= '0;
        end else begin
            tick_cnt_q <= tick_cnt_q + 32'h1;
        end
    end

    // ------------------------------------------------------------
    // Alarm reset pulse
    // ------------------------------------------------------------
    logic reset_req, reset_req_q, reset_armed_q;
    logic [15:0] pulse_cnt_q;
    assign reset_req = reset_contact_in | reset_serial_in | reset_soft_in; // R19
    // Fixed length; a held request cannot stretch it
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            reset_req_q <= 1'b0;
            pulse_cnt_q <= '0;
            reset_armed_q <= 1'b1;
        end else begin
            reset_req_q <= reset_req;
            if (!reset_req) begin
                reset_armed_q <= 1'b1; // R18
            end else if (reset_armed_q && !reset_req_q) begin
                reset_armed_q <= 1'b0;
            end
            if (reset_req && !reset_req_q && reset_armed_q) begin
                pulse_cnt_q <= 16'(RESET_PULSE_TICKS); // R18
            end else if (tick && pulse_cnt_q != 16'h0000) begin
                pulse_cnt_q <= pulse_cnt_q - 16'h1;
            end
        end
    end
    assign alarm_reset_out = (pulse_cnt_q != 16'h0000);

    // ------------------------------------------------------------
    // Analog input supervision
    // ------------------------------------------------------------
    logic [W-1:0] ain_vec [0:2];
    logic [2:0] ain_oor;
    assign ain_vec[csq_pkg::AIN_RACK] = ain_rack_in;
    assign ain_vec[csq_pkg::AIN_REMOTE] = ain_remote_in;
    assign ain_vec[csq_pkg::AIN_MAP] = ain_map_in;
    for (genvar i = 0; i < csq_pkg::N_ANALOG; i++) begin : g_ain
        csq_fault_latch #(.W(W)) u_latch (
            .ref_clk_in(ref_clk_in),
            .reset_in(reset_in),
            .reading_in(ain_vec[i]),
            .volt_mode_in(volt_mode_in[i]),
            .alarm_reset_in(alarm_reset_out),
            .out_of_range_out(ain_oor[i]),
            .failed_out(ain_failed_out[i])
        );
    end

    // Fallbacks; remote reference remembers the last good sample
    logic [W-1:0] remote_hold_q, rack_q;
    logic map_en_q;
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            remote_hold_q <= '0;
            rack_q <= '0;
            map_en_q <= 1'b0;
        end else begin
            if (!ain_failed_out[csq_pkg::AIN_REMOTE] && !ain_oor[csq_pkg::AIN_REMOTE]) begin
                remote_hold_q <= ain_remote_in;
            end
            rack_q <= ain_failed_out[csq_pkg::AIN_RACK] ? actuator_scaled_in : ain_rack_in; // R15
            map_en_q <= !ain_failed_out[csq_pkg::AIN_MAP]; // R17
        end
    end
    assign remote_ref_out = (ain_failed_out[csq_pkg::AIN_REMOTE] && hold_remote_on_fail_in) ?
                            remote_hold_q : ain_remote_in; // R16
    assign rack_value_out = rack_q;
    assign map_limit_enable_out = map_en_q;

    // ------------------------------------------------------------
    // Input F role and clutch status
    // ------------------------------------------------------------
    logic declutch_now, declutch_block_q;
    assign clutch_closed_out = clutch_engaged_in; // R12
    assign declutch_now = !input_f_function_select_in && input_f_in; // R2 R3
    assign torque_limit_active_out = input_f_function_select_in && input_f_in && clutch_closed_out; // R1 R2
    assign declutch_cmd_out = declutch_now || declutch_block_q;
    // Latch until F releases so switching input F to torque-limit role cannot re-clutch
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            declutch_block_q <= 1'b0;
        end else if (declutch_now) begin
            declutch_block_q <= 1'b1;
        end else if (!input_f_in) begin
            declutch_block_q <= 1'b0; // R4
        end
    end

    // ------------------------------------------------------------
    // Clutch sequence
    // ------------------------------------------------------------
    csq_pkg::csq_state_t state_q;
    logic [15:0] dwell_ms_q, ms_q;
    logic [6:0] sec_q;
    logic sync_mode_q, in_window, loads_match;
    logic [W-1:0] load_q, target_q;
    logic [W:0] speed_diff;
    assign speed_diff = (engine_speed_in >= target_q) ? {1'b0, engine_speed_in - target_q}
                                                       : {1'b0, target_q - engine_speed_in};
    assign in_window = speed_diff <= {1'b0, speed_window_in}; // R9
    assign loads_match = load_q >= other_load_in;

    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            state_q <= csq_pkg::CSQ_IDLE;
            sync_mode_q <= 1'b0;
            target_q <= '0;
        end else if (declutch_now) begin
            state_q <= csq_pkg::CSQ_BLOCKED; // R3
        end else begin
            case (state_q)
                csq_pkg::CSQ_IDLE: begin
                    if (clutch_request_in && !declutch_block_q) begin
                        sync_mode_q <= other_clutched_in;
                        target_q <= other_clutched_in ? other_speed_in : idle_speed_in; // R5 R6
                        state_q <= csq_pkg::CSQ_RAMP;
                    end
                end
                csq_pkg::CSQ_RAMP, csq_pkg::CSQ_DWELL: begin
                    if (sync_mode_q) target_q <= other_speed_in; // R6
                    if (!clutch_request_in) begin
                        state_q <= csq_pkg::CSQ_IDLE;
                    end else if (!in_window) begin
                        state_q <= csq_pkg::CSQ_RAMP; // R21
                    end else if (state_q == csq_pkg::CSQ_RAMP) begin
                        state_q <= csq_pkg::CSQ_DWELL;
                    end else if (dwell_ms_q >= sync_dwell_ms_in) begin
                        state_q <= csq_pkg::CSQ_WAIT_ENGAGE; // R5 R6
                    end
                end
                csq_pkg::CSQ_WAIT_ENGAGE: begin
                    if (!clutch_request_in) begin
                        state_q <= csq_pkg::CSQ_IDLE; // R10
                    end else if (clutch_engaged_in) begin
                        state_q <= sync_mode_q ? csq_pkg::CSQ_SOFT_LOAD : csq_pkg::CSQ_SHARING; // R8 R20
                    end else if (sec_q >= engage_timeout_s_in) begin
                        state_q <= csq_pkg::CSQ_IDLE; // R7
                    end
                end
                csq_pkg::CSQ_SOFT_LOAD, csq_pkg::CSQ_SHARING: begin
                    if (state_q == csq_pkg::CSQ_SOFT_LOAD && loads_match) state_q <= csq_pkg::CSQ_SHARING; // R8
                    if (!clutch_request_in) begin
                        state_q <= other_clutched_in ? csq_pkg::CSQ_SOFT_UNLOAD : csq_pkg::CSQ_IDLE; // R10 R11
                    end
                end
                csq_pkg::CSQ_SOFT_UNLOAD: begin
                    if (load_q <= unload_trip_in) state_q <= csq_pkg::CSQ_IDLE; // R11
                end
                csq_pkg::CSQ_BLOCKED: begin
                    if (!input_f_in) state_q <= csq_pkg::CSQ_IDLE; // R4
                end
                default: state_q <= csq_pkg::CSQ_IDLE;
            endcase
        end
    end

    // Dwell timer in ms, restarted whenever speed leaves the window
    always_ff @(posedge ref_clk_in) begin
        if (reset_in || state_q != csq_pkg::CSQ_DWELL || !in_window) begin
            dwell_ms_q <= '0; // R21
        end else if (tick && dwell_ms_q != 16'hFFFF) begin
            dwell_ms_q <= dwell_ms_q + 16'h1;
        end
    end

    // Engage timer runs only while permissive closed and not yet engaged
    always_ff @(posedge ref_clk_in) begin
        if (reset_in || state_q != csq_pkg::CSQ_WAIT_ENGAGE || clutch_engaged_in) begin
            ms_q <= '0; // R20
            sec_q <= '0;
        end else if (tick) begin
            if (ms_q == 16'(csq_pkg::MS_PER_S - 1)) begin
                ms_q <= '0;
                sec_q <= (sec_q == 7'h7F) ? sec_q : sec_q + 7'h1;
            end else begin
                ms_q <= ms_q + 16'h1;
            end
        end
    end

    // Load reference ramps once per tick, saturating at the bounds
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            load_q <= '0;
        end else if (state_q == csq_pkg::CSQ_SOFT_LOAD) begin
            if (tick && !loads_match) load_q <= (other_load_in - load_q < load_rate_in) ?
                                                other_load_in : load_q + load_rate_in; // R8
        end else if (state_q == csq_pkg::CSQ_SOFT_UNLOAD) begin
            if (tick) load_q <= (load_q < unload_rate_in) ? '0 : load_q - unload_rate_in; // R11
        end else if (state_q == csq_pkg::CSQ_SHARING) begin
            load_q <= own_load_in;
        end else begin
            load_q <= '0;
        end
    end

    assign permissive_out = (state_q == csq_pkg::CSQ_WAIT_ENGAGE) || (state_q == csq_pkg::CSQ_SOFT_LOAD) ||
                            (state_q == csq_pkg::CSQ_SHARING) || (state_q == csq_pkg::CSQ_SOFT_UNLOAD);
    assign sync_target_valid_out = (state_q == csq_pkg::CSQ_RAMP) || (state_q == csq_pkg::CSQ_DWELL);
    assign speed_target_out = target_q;
    assign load_ref_out = load_q;
    assign load_sharing_out = (state_q == csq_pkg::CSQ_SHARING);

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_declutch_opens: assert property (@(posedge ref_clk_in) disable iff (reset_in) // R3
        declutch_now |=> !permissive_out) else $error("de-clutch did not open permissive");
    chk_declutch_block: assert property (@(posedge ref_clk_in) disable iff (reset_in) // R4
        declutch_block_q && input_f_in |=> !permissive_out) else $error("clutching while blocked");
    chk_torque_cap: assert property (@(posedge ref_clk_in) disable iff (reset_in) // R1
        torque_limit_active_out |-> input_f_in && clutch_engaged_in) else $error("cap without cause");
    chk_free_open: assert property (@(posedge ref_clk_in) disable iff (reset_in) // R10
        state_q == csq_pkg::CSQ_WAIT_ENGAGE && !clutch_request_in && !declutch_now |=> !permissive_out)
        else $error("permissive not opened on drop");
    chk_engage_timeout: assert property (@(posedge ref_clk_in) disable iff (reset_in) // R7
        state_q == csq_pkg::CSQ_WAIT_ENGAGE && sec_q >= engage_timeout_s_in && clutch_request_in
        && !clutch_engaged_in |=> !permissive_out) else $error("engage timeout ignored");
    chk_dwell_window: assert property (@(posedge ref_clk_in) disable iff (reset_in) // R21
        !in_window |=> dwell_ms_q == 16'h0000) else $error("dwell kept outside window");
    chk_unload_trip: assert property (@(posedge ref_clk_in) disable iff (reset_in) // R11
        state_q == csq_pkg::CSQ_SOFT_UNLOAD && load_q <= unload_trip_in && !declutch_now
        |=> !permissive_out) else $error("unload trip missed");
    chk_reset_pulse: assert property (@(posedge ref_clk_in) disable iff (reset_in) // R18
        alarm_reset_out && !$past(alarm_reset_out) |-> $past(reset_req) && !$past(reset_req, 2))
        else $error("reset without edge");
    chk_map_fallback: assert property (@(posedge ref_clk_in) disable iff (reset_in) // R17
        ain_failed_out[2] |=> !map_limit_enable_out) else $error("map limit left on");
    cov_engage: cover property (@(posedge ref_clk_in) state_q == csq_pkg::CSQ_WAIT_ENGAGE ##1
        state_q == csq_pkg::CSQ_SOFT_LOAD);
    cov_share: cover property (@(posedge ref_clk_in) $rose(load_sharing_out));
    cov_unload: cover property (@(posedge ref_clk_in) state_q == csq_pkg::CSQ_SOFT_UNLOAD);
    cov_fault: cover property (@(posedge ref_clk_in) $fell(ain_failed_out[0]));
endmodule

// *** rtl/csq_fault_latch.sv ***
// Out-of-range detector and latch for one supervised analog input
`timescale 1ns/1ps
module csq_fault_latch #(
    parameter int W = 16
) (
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic reset_in,
    // Reading and mode
    input wire logic [W-1:0] reading_in,
    input wire logic volt_mode_in,
    input wire logic alarm_reset_in,
    // Status
    output logic out_of_range_out,
    output logic failed_out
);
    initial begin
        if (W < 16) $error("csq_fault_latch: W must be at least 16");
    end

    logic failed_q;

    // Window picks current or voltage limits
    always_comb begin
        if (volt_mode_in) begin
            out_of_range_out = (reading_in < W'(csq_pkg::VOLT_LOW_MV)) ||
                               (reading_in > W'(csq_pkg::VOLT_HIGH_MV)); // R13
        end else begin
            out_of_range_out = (reading_in < W'(csq_pkg::CUR_LOW_UA)) ||
                               (reading_in > W'(csq_pkg::CUR_HIGH_UA)); // R13
        end
    end

    // Sticky; a new fault beats the reset, so clearing needs a good reading
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            failed_q <= 1'b0;
        end else if (out_of_range_out) begin
            failed_q <= 1'b1; // R14
        end else if (alarm_reset_in) begin
            failed_q <= 1'b0; // R14
        end
    end
    assign failed_out = failed_q;

    chk_fault_sticky: assert property (@(posedge ref_clk_in) disable iff (reset_in) // R14
        failed_q && !alarm_reset_in |=> failed_q) else $error("fault cleared without reset");
    chk_fault_sets: assert property (@(posedge ref_clk_in) disable iff (reset_in) // R13
        out_of_range_out |=> failed_q) else $error("out of range not latched");
endmodule

// *** rtl/csq_pkg.sv ***
// Package: constants and types for the clutch sequencer and input supervision
package csq_pkg;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ = 200_000_000;
    localparam int unsigned TICK_MS = 1;
    localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
    localparam int unsigned RESET_PULSE_MS = 100;
    localparam int unsigned RESET_PULSE_TICKS = RESET_PULSE_MS / TICK_MS;
    localparam int unsigned ENGAGE_MIN_S = 1;
    localparam int unsigned ENGAGE_MAX_S = 120;
    localparam int unsigned MS_PER_S = 1000;

    // ------------------------------------------------------------
    // Analog supervision, readings in microamps (voltage mode in millivolts)
    // ------------------------------------------------------------
    localparam logic [15:0] CUR_LOW_UA = 16'h07D0;   // 2.0 mA
    localparam logic [15:0] CUR_HIGH_UA = 16'h55F0;  // 22 mA
    localparam logic [15:0] VOLT_LOW_MV = 16'h01F4;  // 0.5 V
    localparam logic [15:0] VOLT_HIGH_MV = 16'h157C; // 5.5 V
    localparam int unsigned N_ANALOG = 3;
    localparam int unsigned AIN_RACK = 0;
    localparam int unsigned AIN_REMOTE = 1;
    localparam int unsigned AIN_MAP = 2;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic INPUT_F_FUNCTION_RESET = 1'b1;  // torque-limit enable

    // ------------------------------------------------------------
    // Clutch sequence states
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        CSQ_IDLE,
        CSQ_RAMP,
        CSQ_DWELL,
        CSQ_WAIT_ENGAGE,
        CSQ_SOFT_LOAD,
        CSQ_SHARING,
        CSQ_SOFT_UNLOAD,
        CSQ_BLOCKED
    } csq_state_t;
endpackage

// *** sim/clutch_sequencer_input_faults_bench.sv ***
// Self-checking bench for the clutch sequencer and input supervision
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin failures++; $display("ERROR %0t mismatch %h %h", $time, a, b); end end
module clutch_sequencer_input_faults_bench;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    localparam int TC = 10;
    logic ref_clk_in = 1'b0;
    logic reset_in = 1'b1;
    logic f = 1'b0, req = 1'b0, oth = 1'b0, sel = 1'b1, hold = 1'b1, eng, xf, stv;
    logic [2:0] src = 3'h0, volt = 3'h0, fail;
    logic [6:0] tmo = 7'h01;
    logic [15:0] ospd = 16'h0500, oload = 16'h0400, trip = 16'h0080, act = 16'h1234, pdly = 16'h0004;
    logic [15:0] idle = 16'h0300, off = 16'h0000, tgt, lref, rack, rem, ain[3], tbl[8];
    logic perm, tq, dcl, clo, shr, ars, mapen;
    int failures = 0, compares = 0, seed = 19786, r, k, lastrem = 12000;
    // Short tick keeps the engage timeout affordable
    always #2.5 ref_clk_in = ~ref_clk_in;
    csq_clutch_seq #(.TICK_CYCLES(TC), .RESET_PULSE_TICKS(2)) u_dut (
        .ref_clk_in(ref_clk_in), .reset_in(reset_in), .input_f_in(f), .clutch_request_in(req),
        .clutch_engaged_in(eng), .other_clutched_in(oth), .reset_contact_in(src[0]), .reset_serial_in(src[1]),
        .reset_soft_in(src[2]), .input_f_function_select_in(sel), .hold_remote_on_fail_in(hold),
        .volt_mode_in(volt), .sync_dwell_ms_in(16'h0002), .speed_window_in(16'h0010), .engage_timeout_s_in(tmo),
        .load_rate_in(16'h0040), .unload_rate_in(16'h0040), .unload_trip_in(trip), .idle_speed_in(idle),
        .other_speed_in(ospd), .engine_speed_in(tgt + off), .own_load_in(lref), .other_load_in(oload),
        .actuator_scaled_in(act), .ain_rack_in(ain[0]), .ain_remote_in(ain[1]), .ain_map_in(ain[2]),
        .permissive_out(perm), .torque_limit_active_out(tq), .declutch_cmd_out(dcl), .clutch_closed_out(clo),
        .sync_target_valid_out(stv), .speed_target_out(tgt), .load_ref_out(lref), .load_sharing_out(shr),
        .alarm_reset_out(ars), .ain_failed_out(fail), .rack_value_out(rack), .remote_ref_out(rem),
        .map_limit_enable_out(mapen));
    csq_partner u_part (.ref_clk_in(ref_clk_in), .permissive_in(perm), .delay_in(pdly), .clutch_engaged_out(eng));
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic step(input int n);
        repeat (n) @(posedge ref_clk_in);
        #1;
    endtask
    // Bounded wait, the caller checks the level reached
    task automatic wperm(input logic v, input int lim);
        for (int i = 0; i < lim && perm !== v; i++) step(1);
    endtask
    // Fault window in microamps, or millivolts in voltage mode
    function automatic logic oor(input int v, input logic vm);
        return vm ? (v < 500 || v > 5500) : (v < 2000 || v > 22000);
    endfunction
    task automatic close_out;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Main sequence
    initial begin
        ain = '{16'h2EE0, 16'h2EE0, 16'h2EE0};
        tbl = '{16'h07CF, 16'h07D0, 16'h55F0, 16'h55F1, 16'h01F3, 16'h01F4, 16'h157C, 16'h157D};
        step(16);
        reset_in = 1'b0;
        step(1);
        `CHK(fail, 3'h0)
        req = 1'b1;
        wperm(1'b1, 20000);
        `CHK(perm, 1'b1)
        `CHK(tgt, idle)
        step(8);
        `CHK(clo, 1'b1)
        `CHK(shr, 1'b1)
        f = 1'b1;
        step(2);
        `CHK(tq, 1'b1)
        f = 1'b0;
        step(2);
        `CHK(tq, 1'b0)
        req = 1'b0;
        step(1);
        `CHK(perm, 1'b0)
        // Dead clutch: permissive must hold a full second then reopen
        pdly = 16'h0000;
        req = 1'b1;
        wperm(1'b1, 20000);
        step(1000 * TC - 100);
        `CHK(perm, 1'b1)
        wperm(1'b0, 300);
        `CHK(perm, 1'b0)
        req = 1'b0;
        pdly = 16'h0004;
        oth = 1'b1;
        // Engine held off the target: no dwell, no permissive
        off = 16'h0020;
        step(2);
        req = 1'b1;
        step(60);
        `CHK(perm, 1'b0)
        `CHK(stv, 1'b1)
        off = 16'h0000;
        wperm(1'b1, 20000);
        `CHK(tgt, ospd)
        for (int i = 0; i < 400 && shr !== 1'b1; i++) step(1);
        `CHK(shr, 1'b1)
        `CHK(lref >= oload, 1'b1)
        req = 1'b0;
        step(2);
        `CHK(perm, 1'b1)
        wperm(1'b0, 400);
        `CHK(lref <= trip, 1'b1)
        sel = 1'b0;
        req = 1'b1;
        wperm(1'b1, 20000);
        step(8);
        f = 1'b1;
        step(1);
        `CHK(dcl, 1'b1)
        `CHK(perm, 1'b0)
        step(100);
        `CHK(perm, 1'b0)
        f = 1'b0;
        wperm(1'b1, 20000);
        `CHK(perm, 1'b1)
        req = 1'b0;
        wperm(1'b0, 2000);
        oth = 1'b0;
        sel = 1'b1;
        // Boundary and random readings, each cleared by a different reset source
        for (int i = 0; i < 24; i++) begin
            r = $random(seed);
            k = i % 3;
            hold = r[5];
            volt[k] = r[3];
            ain[k] = r[4] ? tbl[r[2:0]] : 16'(r[31:17] % 25000);
            xf = oor(int'(ain[k]), r[3]);
            if (!xf && k == 1) lastrem = int'(ain[1]);
            step(2);
            `CHK(fail[k], xf)
            if (xf && k == 0) `CHK(rack, act)
            if (xf && k == 1) `CHK(rem, hold ? lastrem[15:0] : ain[1])
            if (k == 2) `CHK(mapen, !xf)
            ain[k] = r[3] ? 16'h0BB8 : 16'h2EE0;
            if (k == 1) lastrem = int'(ain[1]);
            step(2);
            `CHK(fail[k], xf)
            src[i % 3] = 1'b1;
            step(4);
            `CHK(ars, 1'b1)
            step(40);
            `CHK(ars, 1'b0)
            src = 3'h0;
            step(2);
            `CHK(fail[k], 1'b0)
        end
        close_out();
    end
    // Cut a hang short well past the expected run length
    initial begin
        repeat (80000) @(posedge ref_clk_in);
        failures++;
        close_out();
    end
endmodule

// *** sim/csq_partner.sv ***
// Stand-in for the clutch: closes its engaged contact some time after the permissive
`timescale 1ns/1ps
module csq_partner (
    // Clock
    input wire logic ref_clk_in,
    // Permissive and answer delay in cycles, zero means a dead clutch
    input wire logic permissive_in,
    input wire logic [15:0] delay_in,
    // Clutch engaged contact
    output logic clutch_engaged_out
);
    int cnt_q = 0;
    // Count cycles since the permissive closed
    always @(posedge ref_clk_in) begin
        cnt_q <= permissive_in ? cnt_q + 1 : 0;
    end
    // Clutch drops at once with the permissive, as a real one would
    assign clutch_engaged_out = permissive_in && delay_in != 16'h0000 && cnt_q >= int'(delay_in);
endmodule
